// ---- include/iicr_pkg.sv ----
// Package with register map, field layout, reset values and timing counts.
package iicr_pkg;

  // ----------------------------------------
  // Register offsets.
  // ----------------------------------------
  localparam logic [7:0] IICR_FMT_ADDR = 8'h21;
  localparam logic [7:0] IICR_DIV_ADDR = 8'h22;
  localparam logic [7:0] IICR_PHZ_ADDR = 8'h23;
  localparam logic [7:0] IICR_COMMIT_ADDR = 8'h24;

  // ----------------------------------------
  // Field positions.
  // ----------------------------------------
  localparam int IICR_CODING_BIT = 7;
  localparam int IICR_BUSW_LSB = 5;
  localparam int IICR_WORDW_BIT = 4;
  localparam int IICR_COMPLEX_DATA_SEL_BIT = 3;
  localparam int IICR_LAT_LSB = 0;
  localparam int IICR_DIV_LSB = 4;
  localparam int IICR_SPHZ_LSB = 4;
  localparam int IICR_YPHZ_LSB = 0;
  localparam int IICR_COMMIT_BIT = 7;

  // ----------------------------------------
  // Reset values and fixed read values.
  // ----------------------------------------
  localparam logic [7:0] IICR_FMT_RST = 8'h00;
  localparam logic [2:0] IICR_DIV_RST = 3'h0;
  localparam logic [7:0] IICR_PHZ_RST = 8'h00;
  localparam logic [3:0] IICR_FIXED_NIBBLE = 4'hF;

  // ----------------------------------------
  // Divider codes and half periods in converter clock cycles.
  // ----------------------------------------
  localparam logic [2:0] IICR_DIV_OFF = 3'h0;
  localparam logic [2:0] IICR_DIV_16 = 3'h1;
  localparam logic [2:0] IICR_DIV_32 = 3'h2;
  localparam logic [2:0] IICR_DIV_64 = 3'h4;
  localparam logic [5:0] IICR_HALF_16 = 6'h08;
  localparam logic [5:0] IICR_HALF_32 = 6'h10;
  localparam logic [5:0] IICR_HALF_64 = 6'h20;

  // Decoded input format settings.
  typedef struct packed {
    logic coding_select;
    logic [1:0] input_bus_width_sel;
    logic word_width_sel;
    logic complex_data_sel;
    logic [2:0] frame_sync_latency;
  } iicr_fmt_t;

  // Committed clock settings.
  typedef struct packed {
    logic [2:0] output_clock_divider;
    logic [3:0] sample_clock_phase;
    logic [3:0] sync_clock_phase;
  } iicr_clk_t;

  // Latency sequencer states.
  typedef enum logic [1:0] {
    IICR_IDLE = 2'b01,
    IICR_WAIT = 2'b10
  } iicr_state_t;

endpackage

// ---- src/iicr_regs.sv ----
// Input interface configuration registers with clock divider and frame-sync latency.
`timescale 1ns/1ps
// What this block does
// - Coding bit 7 selects twos complement at 0, straight binary at 1.
// - Bits 6:5 select input bus width 4, 8, 16 or 32 bits.
// - Word width bit selects 8-bit words when clear, 16-bit when set.
// - Bit 3 selects real data at 0, complex data at 1.
// - Latency n starts sampling at output clock rising edge n+1 after frame-sync falls.
// - Divider 000 stops the output clock; 001, 010, 100 divide by 16, 32, 64.
// - Low four bits of the divider register always read 1111.
// - Sample clock phase in bits 7:4 picks one of sixteen phases.
// - Sync clock phase in bits 3:0 picks one of sixteen phases.
// - Format control register sits at address 0x21.
// - Divider and phase values apply only on a 0 to 1 commit bit edge.
module iicr_regs
  import iicr_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic frame_sync_in,
  output logic [7:0] reg_rdata_out,
  output iicr_fmt_t fmt_out,
  output iicr_clk_t clk_cfg_out,
  output logic output_data_clock_out,
  output logic sample_start_out
);

  // ----------------------------------------
  // Register storage.
  // ----------------------------------------
  iicr_fmt_t fmt;
  logic [2:0] div_pend;
  logic [7:0] phz_pend;
  logic commit_bit;
  logic commit_rise;
  iicr_clk_t clk_act;

  assign commit_rise = reg_wr_in && (reg_addr_in == IICR_COMMIT_ADDR) &&
                       reg_wdata_in[IICR_COMMIT_BIT] && !commit_bit;

  // Format control register takes effect at once.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt <= IICR_FMT_RST;
    end else if (reg_wr_in && reg_addr_in == IICR_FMT_ADDR) begin
      fmt.coding_select <= reg_wdata_in[IICR_CODING_BIT];
      fmt.input_bus_width_sel <= reg_wdata_in[IICR_BUSW_LSB +: 2];
      fmt.word_width_sel <= reg_wdata_in[IICR_WORDW_BIT];
      fmt.complex_data_sel <= reg_wdata_in[IICR_COMPLEX_DATA_SEL_BIT];
      fmt.frame_sync_latency <= reg_wdata_in[IICR_LAT_LSB +: 3];
    end
  end

  // Pending divider and phase values wait for a commit.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_pend <= IICR_DIV_RST;
      phz_pend <= IICR_PHZ_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == IICR_DIV_ADDR) begin
        div_pend <= reg_wdata_in[IICR_DIV_LSB +: 3];
      end
      if (reg_wr_in && reg_addr_in == IICR_PHZ_ADDR) begin
        phz_pend <= reg_wdata_in;
      end
    end
  end

  // Commit bit stores the written level; a rising write copies pending to active.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      commit_bit <= 1'b0;
      clk_act <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == IICR_COMMIT_ADDR) begin
        commit_bit <= reg_wdata_in[IICR_COMMIT_BIT];
      end
      if (commit_rise) begin
        clk_act.output_clock_divider <= div_pend;
        clk_act.sample_clock_phase <= phz_pend[IICR_SPHZ_LSB +: 4];
        clk_act.sync_clock_phase <= phz_pend[IICR_YPHZ_LSB +: 4];
      end
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        IICR_FMT_ADDR: reg_rdata_out <= fmt;
        IICR_DIV_ADDR: reg_rdata_out <= {1'b0, div_pend, IICR_FIXED_NIBBLE};
        IICR_PHZ_ADDR: reg_rdata_out <= phz_pend;
        IICR_COMMIT_ADDR: reg_rdata_out <= {commit_bit, 7'h00};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Configuration outputs mirror the registers.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt_out <= IICR_FMT_RST;
      clk_cfg_out <= '0;
    end else begin
      fmt_out <= fmt;
      clk_cfg_out <= clk_act;
    end
  end

  // ----------------------------------------
  // Output data clock divider.
  // ----------------------------------------
  logic [5:0] half_len;
  logic [5:0] div_cnt;
  logic dco_rise;

  // Reserved and zero codes give a zero half period, which holds the clock low.
  always_comb begin
    unique case (clk_act.output_clock_divider)
      IICR_DIV_16: half_len = IICR_HALF_16;
      IICR_DIV_32: half_len = IICR_HALF_32;
      IICR_DIV_64: half_len = IICR_HALF_64;
      default: half_len = 6'h00;
    endcase
  end

  // The divider restarts low on every commit so no runt phase follows a change.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt <= 6'h00;
      output_data_clock_out <= 1'b0;
      dco_rise <= 1'b0;
    end else if (commit_rise || half_len == 6'h00) begin
      div_cnt <= 6'h00;
      output_data_clock_out <= 1'b0;
      dco_rise <= 1'b0;
    end else if (div_cnt == half_len - 6'h01) begin
      div_cnt <= 6'h00;
      output_data_clock_out <= !output_data_clock_out;
      dco_rise <= !output_data_clock_out;
    end else begin
      div_cnt <= div_cnt + 6'h01;
      dco_rise <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frame-sync synchroniser and latency sequencer.
  // ----------------------------------------
  logic fs_s1;
  logic fs_s2;
  logic fs_s3;
  logic fs_level;
  logic fs_fall;
  iicr_state_t state;
  logic [2:0] edge_cnt;

  // Three stages; a change counts once the second and third agree.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fs_s3 <= 1'b0;
      fs_level <= 1'b0;
    end else begin
      fs_s1 <= frame_sync_in;
      fs_s2 <= fs_s1;
      fs_s3 <= fs_s2;
      if (fs_s2 == fs_s3) begin
        fs_level <= fs_s3;
      end
    end
  end

  assign fs_fall = fs_level && (fs_s2 == fs_s3) && !fs_s3;

  // Count output clock rising edges after the fall and pulse at edge n+1.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= IICR_IDLE;
      edge_cnt <= 3'h0;
      sample_start_out <= 1'b0;
    end else begin
      sample_start_out <= 1'b0;
      unique case (state)
        IICR_IDLE: begin
          edge_cnt <= 3'h0;
          if (fs_fall) begin
            state <= IICR_WAIT;
          end
        end
        IICR_WAIT: begin
          if (dco_rise) begin
            if (edge_cnt == fmt.frame_sync_latency) begin
              sample_start_out <= 1'b1;
              state <= IICR_IDLE;
            end else begin
              edge_cnt <= edge_cnt + 3'h1;
            end
          end
        end
        default: state <= IICR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions and covers.
  // ----------------------------------------
  fixed_nibble_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == IICR_DIV_ADDR) |=> reg_rdata_out[3:0] == 4'hF)
    else $error("Divider readback low nibble is not all fixed_high_nibble.");

  fmt_write_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == 8'h21) |=> ##1 fmt_out == $past(reg_wdata_in, 2))
    else $error("Format register write did not reach the outputs.");

  coding_bit_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == 8'h21) |=> ##1 fmt_out.coding_select == $past(reg_wdata_in[7], 2))
    else $error("Coding select does not follow bit 7.");

  no_commit_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !commit_rise |=> clk_act == $past(clk_act))
    else $error("Clock settings changed without a commit edge.");

  commit_apply_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    commit_rise |=> clk_act.sample_clock_phase == $past(phz_pend[7:4]) &&
      clk_act.sync_clock_phase == $past(phz_pend[3:0]) &&
      clk_act.output_clock_divider == $past(div_pend))
    else $error("Commit did not copy pending values.");

  stopped_clock_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (half_len == 6'h00) |=> !output_data_clock_out)
    else $error("Output clock runs with a stop or reserved code.");

  div16_period_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ($rose(output_data_clock_out) && clk_act.output_clock_divider == 3'h1) ##1
    (clk_act.output_clock_divider == 3'h1 && !commit_rise) [*7] |=>
    $fell(output_data_clock_out))
    else $error("Divide by 16 half period is not eight cycles.");

  latency_zero_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (state == IICR_WAIT && dco_rise && edge_cnt == fmt.frame_sync_latency) |=>
    sample_start_out && state == IICR_IDLE)
    else $error("Sampling did not start at the programmed edge.");

  start_needs_wait_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    sample_start_out |-> $past(state == IICR_WAIT && dco_rise))
    else $error("Sampling start without a pending frame-sync.");

  bus_width_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == IICR_FMT_ADDR) |=> ##1
    fmt_out.input_bus_width_sel == $past(reg_wdata_in[6:5], 2))
    else $error("Bus width select does not follow bits 6 to 5.");

  word_width_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == IICR_FMT_ADDR) |=> ##1
    fmt_out.word_width_sel == $past(reg_wdata_in[4], 2))
    else $error("Word width select does not follow bit 4.");

  complex_sel_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == IICR_FMT_ADDR) |=> ##1
    fmt_out.complex_data_sel == $past(reg_wdata_in[3], 2))
    else $error("Complex select does not follow bit 3.");

  sample_phase_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    commit_rise |=> ##1 clk_cfg_out.sample_clock_phase == $past(phz_pend[7:4], 2))
    else $error("Sample clock phase output does not follow the commit.");

  sync_phase_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    commit_rise |=> ##1 clk_cfg_out.sync_clock_phase == $past(phz_pend[3:0], 2))
    else $error("Sync clock phase output does not follow the commit.");

  start_pulse_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    sample_start_out |=> !sample_start_out)
    else $error("Sampling start pulse lasts more than one cycle.");

  fs_accept_a: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    (state == IICR_IDLE && fs_fall) |=> state == IICR_WAIT)
    else $error("Frame-sync fall did not start the latency count.");

  cov_commit_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in) commit_rise);
  cov_div64_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    clk_act.output_clock_divider == 3'h4 && $rose(output_data_clock_out));
  cov_start_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    sample_start_out && fmt.frame_sync_latency == 3'h7);
  cov_lat0_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
    sample_start_out && fmt.frame_sync_latency == 3'h0);

endmodule // iicr_regs

// ---- test/iicr_src.sv ----
// Frame-sync source model standing for the external data source.
`timescale 1ns/1ps
module iicr_src (
  input wire logic dclk_in,
  input wire logic start_in,
  output logic frame_sync_out
);
  // The sync line idles high and drops just after an output clock fall, for twelve clocks.
  initial begin
    frame_sync_out = 1'b1;
    forever begin
      @(posedge start_in);
      @(negedge dclk_in);
      frame_sync_out <= 1'b0;
      repeat (12) @(negedge dclk_in);
      frame_sync_out <= 1'b1;
    end
  end
endmodule // iicr_src

// ---- test/test_iicr_regs.sv ----
// Self-checking bench for the input interface configuration registers.
`timescale 1ns/1ps
module test_iicr_regs;
  import iicr_pkg::*;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic start = 1'b0;
  logic frame_sync;
  logic [7:0] reg_rdata_out;
  iicr_fmt_t fmt_out;
  iicr_clk_t clk_cfg_out;
  logic output_data_clock_out;
  logic sample_start_out;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  // The design and the frame-sync source it paces.
  iicr_regs uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .frame_sync_in(frame_sync), .reg_rdata_out(reg_rdata_out), .fmt_out(fmt_out),
    .clk_cfg_out(clk_cfg_out), .output_data_clock_out(output_data_clock_out),
    .sample_start_out(sample_start_out));
  iicr_src src (.dclk_in(output_data_clock_out), .start_in(start), .frame_sync_out(frame_sync));

  // The 40 MHz converter clock.
  always #12.5 core_clk_in = ~core_clk_in;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_out;
  endtask

  task automatic settle;
    repeat (3) @(negedge core_clk_in);
  endtask

  task automatic commit;
    wr(IICR_COMMIT_ADDR, 8'h00);
    wr(IICR_COMMIT_ADDR, 8'h80);
    settle();
  endtask

  // Counts core cycles up to the next rise of the output data clock.
  task automatic rise_wait(output int n);
    logic p;
    n = 0;
    p = output_data_clock_out;
    while (n < 200 && !(output_data_clock_out === 1'b1 && p === 1'b0)) begin
      p = output_data_clock_out;
      @(negedge core_clk_in);
      n++;
    end
  endtask

  task automatic t_reset;
    chk(16'(fmt_out), 16'h0000);
    chk(16'(clk_cfg_out), 16'h0000);
    chk({6'h00, reg_rdata_out, output_data_clock_out, sample_start_out}, 16'h0000);
  endtask

  task automatic t_format;
    logic [7:0] v;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      v = {k[0], k[1:0], ~k[0], k[1], 3'(2 * k + 1)};
      wr(IICR_FMT_ADDR, v);
      settle();
      chk(16'(fmt_out.coding_select), 16'(v[7]));
      chk(16'(fmt_out.input_bus_width_sel), 16'(v[6:5]));
      chk(16'(fmt_out.word_width_sel), 16'(v[4]));
      chk(16'(fmt_out.complex_data_sel), 16'(v[3]));
      chk(16'(fmt_out.frame_sync_latency), 16'(v[2:0]));
      rd(IICR_FMT_ADDR, d);
      chk(16'(d), 16'(v));
    end
  endtask

  task automatic t_phase;
    logic [7:0] d;
    wr(IICR_PHZ_ADDR, 8'hA5);
    settle();
    chk(16'(clk_cfg_out), 16'h0000);
    commit();
    chk(16'(clk_cfg_out.sample_clock_phase), 16'h000A);
    chk(16'(clk_cfg_out.sync_clock_phase), 16'h0005);
    rd(IICR_PHZ_ADDR, d);
    chk(16'(d), 16'h00A5);
    rd(8'h30, d);
    chk(16'(d), 16'h0000);
    // A second set of the commit bit without a clear must not apply new phases.
    wr(IICR_PHZ_ADDR, 8'h3C);
    wr(IICR_COMMIT_ADDR, 8'h80);
    settle();
    chk(16'(clk_cfg_out.sample_clock_phase), 16'h000A);
    chk(16'(clk_cfg_out.sync_clock_phase), 16'h0005);
  endtask

  task automatic t_divider;
    logic [2:0] codes [3] = '{3'h1, 3'h2, 3'h4};
    int divs [3] = '{16, 32, 64};
    logic [2:0] stops [3] = '{3'h3, 3'h6, 3'h0};
    logic [2:0] prev;
    logic [7:0] d;
    int n;
    prev = 3'h0;
    for (int i = 0; i < 3; i++) begin
      wr(IICR_DIV_ADDR, {1'b1, codes[i], 4'h0});
      rd(IICR_DIV_ADDR, d);
      chk(16'(d), 16'({1'b0, codes[i], 4'hF}));
      chk(16'(clk_cfg_out.output_clock_divider), 16'(prev));
      commit();
      chk(16'(clk_cfg_out.output_clock_divider), 16'(codes[i]));
      rise_wait(n);
      rise_wait(n);
      chk(16'(n), 16'(divs[i]));
      prev = codes[i];
    end
    for (int j = 0; j < 3; j++) begin
      wr(IICR_DIV_ADDR, {1'b0, stops[j], 4'h0});
      commit();
      n = 0;
      repeat (150) @(negedge core_clk_in) n += (output_data_clock_out !== 1'b0);
      chk(16'(n), 16'h0000);
    end
  endtask

  task automatic t_latency;
    logic [2:0] lats [3] = '{3'h0, 3'h3, 3'h7};
    logic p;
    int n;
    int k;
    wr(IICR_DIV_ADDR, {1'b0, IICR_DIV_16, 4'h0});
    commit();
    for (int i = 0; i < 3; i++) begin
      wr(IICR_FMT_ADDR, {5'h00, lats[i]});
      settle();
      @(negedge core_clk_in);
      start = 1'b1;
      n = 0;
      k = 0;
      p = output_data_clock_out;
      while (k < 2000 && sample_start_out !== 1'b1) begin
        @(negedge core_clk_in);
        n += (frame_sync === 1'b0 && p === 1'b0 && output_data_clock_out === 1'b1);
        p = output_data_clock_out;
        k++;
      end
      start = 1'b0;
      chk(16'(n), 16'(lats[i]) + 16'h0001);
      repeat (250) @(negedge core_clk_in);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence after a reset of twenty clocks.
  initial begin
    repeat (20) @(negedge core_clk_in);
    nrst_in = 1'b1;
    @(negedge core_clk_in);
    t_reset();
    t_format();
    t_phase();
    t_divider();
    t_latency();
    finish_test();
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
endmodule // test_iicr_regs
